/* hw/dso_params.svh */
`ifndef DSO_PARAMS_SVH
`define DSO_PARAMS_SVH
// Operation
// - Leaving enabled for ready-to-switch-on: 0 cuts current, 1 decelerates then de-energizes.
// - Leaving enabled for switched-on: 0 cuts current, 1 decelerates then de-energizes.
// - Halt selector acts on control word bit 8, accepts 1, 2, 3, resets to 1.
// - Halt: 1 profile decel, 2 quick-stop decel, 3 stop at once; stay enabled.
// - Mode codes 0 none, 1, 3, 6, 8, 9 as named modes; reset 0.
// - Mode written while moving is applied only once the motor stops.
// - Read-only mode display shows the mode in force, same coding.
// - Command position readout, folded into wrap range when wrapping is on.
// - Measured position readout, folded into wrap range when wrapping is on.
// - Deviation alarm above limit in 0.01 rev units, 1 to 30000, reset 300.
// - Settled output within window in 0.1 degree units, 0 to 180, reset 18.
// - Settled window is shifted by a separate offset input.
// - Read-only command speed readout in hertz.
// - Read-only feedback speed readout in hertz.
// - Writable goal position, destination for position modes, reset 0.
// - Positions, mode shown, speeds go out as transmit data; mode, goal come in.

`define DSO_IDX_SHUTDOWN 16'h605b
`define DSO_IDX_DISABLE 16'h605c
`define DSO_IDX_HALT 16'h605d
`define DSO_IDX_MODE_SEL 16'h6060
`define DSO_IDX_MODE_SHOWN 16'h6061
`define DSO_IDX_CMD_POS 16'h6062
`define DSO_IDX_MEAS_POS 16'h6064
`define DSO_IDX_DEV_LIMIT 16'h6065
`define DSO_IDX_SETTLE 16'h6067
`define DSO_IDX_CMD_SPEED 16'h606b
`define DSO_IDX_FB_SPEED 16'h606c
`define DSO_IDX_GOAL 16'h607a

`define DSO_RST_STOP_OPT 16'h0001
`define DSO_RST_DEV_LIMIT 32'h0000012c
`define DSO_RST_SETTLE 32'h00000012
`define DSO_RST_GOAL 32'h00000000

`define DSO_OPT_CUT 16'h0000
`define DSO_OPT_PROFILE 16'h0001
`define DSO_OPT_QUICK 16'h0002
`define DSO_OPT_NOW 16'h0003

`define DSO_DEV_MIN 32'h00000001
`define DSO_DEV_MAX 32'h00007530
`define DSO_SETTLE_MAX 32'h000000b4
`define DSO_HALT_BIT 8
`define DSO_DEV_SCALE 64'h0000000000000064
`define DSO_WIN_SCALE 64'h0000000000000e10
`endif

/* hw/dso_pkg.sv */
package dso_pkg;
   typedef enum logic [7:0] {
      dso_no_mode = 8'h00,
      profile_position_mode = 8'h01,
      profile_velocity_mode = 8'h03,
      homing_mode = 8'h06,
      cyclic_sync_position_mode = 8'h08,
      cyclic_sync_velocity_mode = 8'h09
   } dso_mode_t;
   typedef enum logic [1:0] {dso_dec_none = 2'h0, dso_dec_profile = 2'h1, dso_dec_quick = 2'h2,
      dso_dec_now = 2'h3} dso_decel_t;
   typedef enum logic [3:0] {dso_st_run = 4'b0001, dso_st_decel = 4'b0010, dso_st_off = 4'b0100,
      dso_st_halt = 4'b1000} dso_stop_state_t;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] index;
      logic [31:0] wdata;
   } dso_obj_req_t;
   typedef struct packed {
      logic ack;
      logic err;
      logic [31:0] rdata;
   } dso_obj_rsp_t;
   typedef struct packed {
      logic signed [31:0] cmd_pos;
      logic signed [31:0] meas_pos;
      logic [7:0] mode_shown;
      logic signed [31:0] cmd_speed;
      logic signed [31:0] fb_speed;
   } dso_txpdo_t;
endpackage

/* hw/dso_stop_seq.sv */
`include "dso_params.svh"

module dso_stop_seq (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic leave_to_ready,
   input wire logic leave_to_switched,
   input wire logic halt_bit,
   input wire logic op_enabled,
   input wire logic motor_moving,
   input wire logic [15:0] shutdown_opt,
   input wire logic [15:0] disable_opt,
   input wire logic [15:0] halt_opt,
   output dso_pkg::dso_decel_t decel_ff,
   output logic power_off_ff
);
   dso_pkg::dso_stop_state_t state_ff;
   logic leaving;
   logic [15:0] leave_opt;
   dso_pkg::dso_decel_t halt_kind;

   assign leaving = leave_to_ready | leave_to_switched;
   assign leave_opt = leave_to_ready ? shutdown_opt : disable_opt;
   assign halt_kind = (halt_opt == `DSO_OPT_QUICK) ? dso_pkg::dso_dec_quick :
      (halt_opt == `DSO_OPT_NOW) ? dso_pkg::dso_dec_now : dso_pkg::dso_dec_profile;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= dso_pkg::dso_st_run;
         decel_ff <= dso_pkg::dso_dec_none;
         power_off_ff <= 1'b0;
      end else begin
         unique case (state_ff)
            dso_pkg::dso_st_run, dso_pkg::dso_st_halt: begin
               if (leaving && leave_opt == `DSO_OPT_CUT) begin
                  state_ff <= dso_pkg::dso_st_off;
                  decel_ff <= dso_pkg::dso_dec_none;
                  power_off_ff <= 1'b1;
               end else if (leaving) begin
                  state_ff <= dso_pkg::dso_st_decel;
                  decel_ff <= dso_pkg::dso_dec_profile;
               end else if (halt_bit) begin
                  state_ff <= dso_pkg::dso_st_halt;
                  decel_ff <= halt_kind;
               end else begin
                  state_ff <= dso_pkg::dso_st_run;
                  decel_ff <= dso_pkg::dso_dec_none;
               end
            end
            dso_pkg::dso_st_decel: begin
               if (!motor_moving) begin
                  state_ff <= dso_pkg::dso_st_off;
                  decel_ff <= dso_pkg::dso_dec_none;
                  power_off_ff <= 1'b1;
               end
            end
            dso_pkg::dso_st_off: begin
               if (op_enabled) begin
                  state_ff <= dso_pkg::dso_st_run;
                  power_off_ff <= 1'b0;
               end
            end
         endcase
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   property p_cut;
      state_ff == dso_pkg::dso_st_run && leave_to_ready && shutdown_opt == `DSO_OPT_CUT |=> power_off_ff;
   endproperty
   a_cut: assert property (p_cut) else $error("Shutdown option 0 did not cut current");
   property p_decel_then_off;
      state_ff == dso_pkg::dso_st_run && leave_to_switched && !leave_to_ready && disable_opt == `DSO_OPT_PROFILE
      |=> decel_ff == dso_pkg::dso_dec_profile && !power_off_ff;
   endproperty
   a_decel_then_off: assert property (p_decel_then_off) else $error("Disable option 1 did not decelerate");
   property p_halt_quick;
      state_ff == dso_pkg::dso_st_run && !leaving && halt_bit && halt_opt == `DSO_OPT_QUICK
      |=> decel_ff == dso_pkg::dso_dec_quick && !power_off_ff;
   endproperty
   a_halt_quick: assert property (p_halt_quick) else $error("Halt option 2 not quick decel");
   c_halt: cover property (state_ff == dso_pkg::dso_st_halt ##1 state_ff == dso_pkg::dso_st_run);
endmodule // dso_stop_seq

/* hw/dso_top.sv */
`include "dso_params.svh"

module dso_top #(
   parameter int STEPS_PER_REV = 1000
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input dso_pkg::dso_obj_req_t obj_req,
   output dso_pkg::dso_obj_rsp_t obj_rsp,
   input wire logic rx_mode_valid,
   input wire logic [7:0] rx_mode,
   input wire logic rx_goal_valid,
   input wire logic signed [31:0] rx_goal,
   output dso_pkg::dso_txpdo_t tx_pdo,
   input wire logic [15:0] control_word,
   input wire logic leave_to_ready,
   input wire logic leave_to_switched,
   input wire logic op_enabled,
   input wire logic motor_moving,
   input wire logic signed [31:0] cmd_pos_in,
   input wire logic signed [31:0] meas_pos_in,
   input wire logic signed [31:0] cmd_speed_in,
   input wire logic signed [31:0] fb_speed_in,
   input wire logic wrap_on,
   input wire logic [31:0] wrap_range,
   input wire logic signed [31:0] settle_offset,
   output logic signed [31:0] goal_position,
   output logic [7:0] mode_active,
   output dso_pkg::dso_decel_t decel_kind,
   output logic power_off,
   output logic dev_alarm,
   output logic in_pos
);
   logic [15:0] shutdown_stop_select_ff;
   logic [15:0] disable_stop_select_ff;
   logic [15:0] halt_stop_select_ff;
   logic [7:0] operating_mode_select_ff;
   logic [7:0] operating_mode_shown_ff;
   logic [31:0] deviation_alarm_limit_ff;
   logic [31:0] settle_window_ff;
   logic signed [31:0] goal_position_ff;
   dso_pkg::dso_txpdo_t tx_ff;
   dso_pkg::dso_obj_rsp_t obj_rsp_ff;

   logic obj_wr;
   logic obj_rd;
   logic hit;
   logic writable;
   logic wr_ok;
   logic [31:0] rd_data;
   logic [7:0] nxt_mode_select;
   logic signed [31:0] nxt_goal;

   function automatic logic mode_ok(input logic [31:0] v);
      logic ok;
      ok = 1'b0;
      if (v[31:8] == 24'h000000) begin
         case (v[7:0])
            dso_pkg::dso_no_mode, dso_pkg::profile_position_mode, dso_pkg::profile_velocity_mode,
            dso_pkg::homing_mode, dso_pkg::cyclic_sync_position_mode,
            dso_pkg::cyclic_sync_velocity_mode: ok = 1'b1;
            default: ok = 1'b0;
         endcase
      end
      return ok;
   endfunction

   function automatic logic signed [31:0] fold(input logic signed [31:0] v, input logic on,
      input logic [31:0] range);
      logic signed [32:0] r;
      logic signed [32:0] m;
      r = 33'sd0;
      m = $signed({1'b0, range});
      if (on && range != 32'h00000000) begin
         r = 33'(v) % m;
         if (r < 33'sd0) begin
            r = r + m;
         end
         return r[31:0];
      end
      return v;
   endfunction

   assign obj_wr = obj_req.wr;
   assign obj_rd = obj_req.rd & ~obj_req.wr;

   // Index decode, value check and read mux
   always_comb begin
      hit = 1'b1;
      writable = 1'b0;
      wr_ok = 1'b0;
      rd_data = 32'h00000000;
      case (obj_req.index)
         `DSO_IDX_SHUTDOWN: begin
            writable = 1'b1;
            rd_data = {16'h0000, shutdown_stop_select_ff};
            wr_ok = obj_req.wdata == {16'h0000, `DSO_OPT_CUT} ||
               obj_req.wdata == {16'h0000, `DSO_OPT_PROFILE};
         end
         `DSO_IDX_DISABLE: begin
            writable = 1'b1;
            rd_data = {16'h0000, disable_stop_select_ff};
            wr_ok = obj_req.wdata == {16'h0000, `DSO_OPT_CUT} ||
               obj_req.wdata == {16'h0000, `DSO_OPT_PROFILE};
         end
         `DSO_IDX_HALT: begin
            writable = 1'b1;
            rd_data = {16'h0000, halt_stop_select_ff};
            wr_ok = obj_req.wdata == {16'h0000, `DSO_OPT_PROFILE} ||
               obj_req.wdata == {16'h0000, `DSO_OPT_QUICK} ||
               obj_req.wdata == {16'h0000, `DSO_OPT_NOW};
         end
         `DSO_IDX_MODE_SEL: begin
            writable = 1'b1;
            rd_data = {24'h000000, operating_mode_select_ff};
            wr_ok = mode_ok(obj_req.wdata);
         end
         `DSO_IDX_MODE_SHOWN: begin
            rd_data = {24'h000000, operating_mode_shown_ff};
         end
         `DSO_IDX_CMD_POS: begin
            rd_data = tx_ff.cmd_pos;
         end
         `DSO_IDX_MEAS_POS: begin
            rd_data = tx_ff.meas_pos;
         end
         `DSO_IDX_DEV_LIMIT: begin
            writable = 1'b1;
            rd_data = deviation_alarm_limit_ff;
            wr_ok = obj_req.wdata >= `DSO_DEV_MIN && obj_req.wdata <= `DSO_DEV_MAX;
         end
         `DSO_IDX_SETTLE: begin
            writable = 1'b1;
            rd_data = settle_window_ff;
            wr_ok = obj_req.wdata <= `DSO_SETTLE_MAX;
         end
         `DSO_IDX_CMD_SPEED: begin
            rd_data = tx_ff.cmd_speed;
         end
         `DSO_IDX_FB_SPEED: begin
            rd_data = tx_ff.fb_speed;
         end
         `DSO_IDX_GOAL: begin
            writable = 1'b1;
            rd_data = goal_position_ff;
            wr_ok = 1'b1;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   // Object answer one cycle after the request
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         obj_rsp_ff <= '0;
      end else begin
         obj_rsp_ff.ack <= obj_wr | obj_rd;
         obj_rsp_ff.err <= (obj_wr & ~(hit & writable & wr_ok)) | (obj_rd & ~hit);
         obj_rsp_ff.rdata <= obj_rd && hit ? rd_data : 32'h00000000;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         shutdown_stop_select_ff <= `DSO_RST_STOP_OPT;
         disable_stop_select_ff <= `DSO_RST_STOP_OPT;
         halt_stop_select_ff <= `DSO_RST_STOP_OPT;
      end else if (obj_wr && wr_ok) begin
         if (obj_req.index == `DSO_IDX_SHUTDOWN) begin
            shutdown_stop_select_ff <= obj_req.wdata[15:0];
         end
         if (obj_req.index == `DSO_IDX_DISABLE) begin
            disable_stop_select_ff <= obj_req.wdata[15:0];
         end
         if (obj_req.index == `DSO_IDX_HALT) begin
            halt_stop_select_ff <= obj_req.wdata[15:0];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         deviation_alarm_limit_ff <= `DSO_RST_DEV_LIMIT;
         settle_window_ff <= `DSO_RST_SETTLE;
      end else if (obj_wr && wr_ok) begin
         if (obj_req.index == `DSO_IDX_DEV_LIMIT) begin
            deviation_alarm_limit_ff <= obj_req.wdata;
         end
         if (obj_req.index == `DSO_IDX_SETTLE) begin
            settle_window_ff <= obj_req.wdata;
         end
      end
   end

   // Object write overrides a receive-data update in the same cycle
   always_comb begin
      nxt_mode_select = operating_mode_select_ff;
      if (rx_mode_valid && mode_ok({24'h000000, rx_mode})) begin
         nxt_mode_select = rx_mode;
      end
      if (obj_wr && wr_ok && obj_req.index == `DSO_IDX_MODE_SEL) begin
         nxt_mode_select = obj_req.wdata[7:0];
      end
   end

   always_comb begin
      nxt_goal = goal_position_ff;
      if (rx_goal_valid) begin
         nxt_goal = rx_goal;
      end
      if (obj_wr && obj_req.index == `DSO_IDX_GOAL) begin
         nxt_goal = obj_req.wdata;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         operating_mode_select_ff <= dso_pkg::dso_no_mode;
         goal_position_ff <= `DSO_RST_GOAL;
      end else begin
         operating_mode_select_ff <= nxt_mode_select;
         goal_position_ff <= nxt_goal;
      end
   end

   // Mode takes effect only at standstill
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         operating_mode_shown_ff <= dso_pkg::dso_no_mode;
      end else if (!motor_moving) begin
         operating_mode_shown_ff <= operating_mode_select_ff;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tx_ff <= '0;
      end else begin
         tx_ff.cmd_pos <= fold(cmd_pos_in, wrap_on, wrap_range);
         tx_ff.meas_pos <= fold(meas_pos_in, wrap_on, wrap_range);
         tx_ff.mode_shown <= operating_mode_shown_ff;
         tx_ff.cmd_speed <= cmd_speed_in;
         tx_ff.fb_speed <= fb_speed_in;
      end
   end

   dso_stop_seq u_stop_seq (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .leave_to_ready(leave_to_ready),
      .leave_to_switched(leave_to_switched),
      .halt_bit(control_word[`DSO_HALT_BIT]),
      .op_enabled(op_enabled),
      .motor_moving(motor_moving),
      .shutdown_opt(shutdown_stop_select_ff),
      .disable_opt(disable_stop_select_ff),
      .halt_opt(halt_stop_select_ff),
      .decel_ff(decel_kind),
      .power_off_ff(power_off)
   );

   dso_window_chk #(
      .STEPS_PER_REV(STEPS_PER_REV)
   ) u_window_chk (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .cmd_pos(cmd_pos_in),
      .meas_pos(meas_pos_in),
      .pos_offset(settle_offset),
      .dev_limit(deviation_alarm_limit_ff),
      .settle_window(settle_window_ff),
      .dev_alarm_ff(dev_alarm),
      .in_pos_ff(in_pos)
   );

   assign obj_rsp = obj_rsp_ff;
   assign tx_pdo = tx_ff;
   assign goal_position = goal_position_ff;
   assign mode_active = operating_mode_shown_ff;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   property p_mode_defer;
      motor_moving |=> $stable(operating_mode_shown_ff);
   endproperty
   a_mode_defer: assert property (p_mode_defer) else $error("Mode changed while moving");

   property p_mode_apply;
      !motor_moving ##1 !motor_moving |-> operating_mode_shown_ff == $past(operating_mode_select_ff);
   endproperty
   a_mode_apply: assert property (p_mode_apply) else $error("Mode not applied at standstill");

   property p_mode_reject;
      obj_wr && obj_req.index == `DSO_IDX_MODE_SEL && obj_req.wdata == 32'h00000002 && !rx_mode_valid
      |=> $stable(operating_mode_select_ff) ##0 obj_rsp_ff.err;
   endproperty
   a_mode_reject: assert property (p_mode_reject) else $error("Illegal mode accepted");

   property p_limit_reject;
      obj_wr && obj_req.index == `DSO_IDX_DEV_LIMIT && obj_req.wdata == 32'h00000000
      |=> $stable(deviation_alarm_limit_ff) ##0 obj_rsp_ff.err ##0 obj_rsp_ff.ack;
   endproperty
   a_limit_reject: assert property (p_limit_reject) else $error("Zero alarm limit accepted");

   property p_goal_rx;
      rx_goal_valid && !(obj_wr && obj_req.index == `DSO_IDX_GOAL) |=> goal_position == $past(rx_goal);
   endproperty
   a_goal_rx: assert property (p_goal_rx) else $error("Goal position not taken from receive data");

   property p_wrap_cmd;
      wrap_on && wrap_range != 32'h00000000 |=> $unsigned(tx_ff.cmd_pos) < $past(wrap_range);
   endproperty
   a_wrap_cmd: assert property (p_wrap_cmd) else $error("Command position outside wrap range");

   property p_meas_raw;
      !wrap_on |=> tx_ff.meas_pos == $past(meas_pos_in);
   endproperty
   a_meas_raw: assert property (p_meas_raw) else $error("Measured position altered without wrap");

   property p_speed;
      1'b1 |=> tx_ff.cmd_speed == $past(cmd_speed_in) && tx_ff.fb_speed == $past(fb_speed_in);
   endproperty
   a_speed: assert property (p_speed) else $error("Speed readout stale");

   c_deferred_mode: cover property (motor_moving && operating_mode_select_ff != operating_mode_shown_ff
      ##1 !motor_moving ##1 operating_mode_select_ff == operating_mode_shown_ff);
   c_reject: cover property (obj_rsp_ff.ack && obj_rsp_ff.err);
endmodule // dso_top

/* hw/dso_window_chk.sv */
`include "dso_params.svh"

module dso_window_chk #(
   parameter int STEPS_PER_REV = 1000
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic signed [31:0] cmd_pos,
   input wire logic signed [31:0] meas_pos,
   input wire logic signed [31:0] pos_offset,
   input wire logic [31:0] dev_limit,
   input wire logic [31:0] settle_window,
   output logic dev_alarm_ff,
   output logic in_pos_ff
);
   localparam logic [63:0] SPR = 64'(STEPS_PER_REV);
   logic signed [33:0] dev;
   logic signed [33:0] shifted;
   logic [63:0] dev_mag;
   logic [63:0] shift_mag;
   logic [63:0] dev_lim_steps;
   logic [63:0] win_steps;

   assign dev = 34'(cmd_pos) - 34'(meas_pos);
   assign shifted = dev - 34'(pos_offset);
   assign dev_mag = 64'(dev[33] ? -dev : dev) * `DSO_DEV_SCALE;
   assign shift_mag = 64'(shifted[33] ? -shifted : shifted) * `DSO_WIN_SCALE;
   assign dev_lim_steps = {32'h00000000, dev_limit} * SPR;
   assign win_steps = {32'h00000000, settle_window} * SPR;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         dev_alarm_ff <= 1'b0;
      end else begin
         dev_alarm_ff <= dev_mag > dev_lim_steps;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         in_pos_ff <= 1'b0;
      end else begin
         in_pos_ff <= shift_mag <= win_steps;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   property p_dev_zero;
      cmd_pos == meas_pos |=> !dev_alarm_ff;
   endproperty
   a_dev_zero: assert property (p_dev_zero) else $error("Alarm raised with no deviation");
   property p_inpos_exact;
      34'(cmd_pos) - 34'(meas_pos) == 34'(pos_offset) |=> in_pos_ff;
   endproperty
   a_inpos_exact: assert property (p_inpos_exact) else $error("Settled output missing at offset");
   c_alarm: cover property (!dev_alarm_ff ##1 dev_alarm_ff);
endmodule // dso_window_chk

/* test/dso_master_model.sv */
module dso_master_model (
   input wire logic clk_sys,
   input wire logic send,
   input wire logic [7:0] mode,
   input wire logic signed [31:0] goal,
   input wire logic motor_moving,
   output logic rx_mode_valid,
   output logic [7:0] rx_mode,
   output logic rx_goal_valid,
   output logic signed [31:0] rx_goal
);
   timeunit 1ns;
   timeprecision 1ns;
   logic pend;
   logic [7:0] hold;
   logic go;
   assign go = (send | pend) & ~motor_moving;
   initial begin
      rx_mode_valid = 1'b0;
      rx_mode = 8'h00;
      rx_goal_valid = 1'b0;
      rx_goal = 32'h0;
      pend = 1'b0;
      hold = 8'h00;
   end
   // Mode held back until standstill; idle data toggles
   always @(posedge clk_sys) begin
      rx_goal_valid <= send;
      rx_goal <= send ? goal : ~rx_goal;
      rx_mode_valid <= go;
      rx_mode <= go ? (send ? mode : hold) : ~rx_mode;
      if (send) hold <= mode;
      pend <= (send | pend) & motor_moving;
   end
endmodule // dso_master_model

/* test/test_drive_stop_mode_objects.sv */
`include "dso_params.svh"
module test_drive_stop_mode_objects;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys, rst_n, rxm_v, rxg_v, l_rdy, l_sw, op_en, moving, wrap_on, send, pwr, alarm, in_pos;
   logic [7:0] rxm, mode_act, send_mode;
   logic [15:0] cw;
   logic signed [31:0] rxg, cmd_p, meas_p, cmd_s, fb_s, offs, goal, send_goal;
   logic [31:0] wrap_rng;
   dso_pkg::dso_obj_req_t req;
   dso_pkg::dso_obj_rsp_t rsp;
   dso_pkg::dso_txpdo_t tx;
   dso_pkg::dso_decel_t decel;
   int error_cnt = 0;
   int checked = 0;
   int k;
   dso_top #(.STEPS_PER_REV(100)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .obj_req(req), .obj_rsp(rsp),
      .rx_mode_valid(rxm_v), .rx_mode(rxm), .rx_goal_valid(rxg_v), .rx_goal(rxg), .tx_pdo(tx),
      .control_word(cw), .leave_to_ready(l_rdy), .leave_to_switched(l_sw), .op_enabled(op_en),
      .motor_moving(moving), .cmd_pos_in(cmd_p), .meas_pos_in(meas_p), .cmd_speed_in(cmd_s),
      .fb_speed_in(fb_s), .wrap_on(wrap_on), .wrap_range(wrap_rng), .settle_offset(offs),
      .goal_position(goal), .mode_active(mode_act), .decel_kind(decel), .power_off(pwr),
      .dev_alarm(alarm), .in_pos(in_pos));
   dso_master_model u_master (.clk_sys(clk_sys), .send(send), .mode(send_mode), .goal(send_goal),
      .motor_moving(moving), .rx_mode_valid(rxm_v), .rx_mode(rxm), .rx_goal_valid(rxg_v), .rx_goal(rxg));
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   task automatic summarize();
      if (error_cnt == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (s !== e) begin
         error_cnt++;
         $display("BAD %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic acc(input logic w, input logic [15:0] i, input logic [31:0] d, output logic [32:0] r);
      @(posedge clk_sys) req <= '{wr: w, rd: !w, index: i, wdata: d};
      @(posedge clk_sys) req <= '0;
      #1 chk("ack", 32'h1, 32'(rsp.ack));
      r = {rsp.err, rsp.rdata};
   endtask
   task automatic wr(input logic [15:0] i, input logic [31:0] d, input logic ee);
      logic [32:0] r;
      acc(1'b1, i, d, r);
      chk("wr err", 32'(ee), 32'(r[32]));
   endtask
   task automatic rd(input logic [15:0] i, input logic [32:0] x);
      logic [32:0] r;
      acc(1'b0, i, 32'h0, r);
      chk("rd", x[31:0], r[31:0]);
      chk("rd err", 32'(x[32]), 32'(r[32]));
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic t_reset();
      rd(`DSO_IDX_SHUTDOWN, 33'h1);
      rd(`DSO_IDX_DISABLE, 33'h1);
      rd(`DSO_IDX_HALT, 33'h1);
      rd(`DSO_IDX_MODE_SEL, 33'h0);
      rd(`DSO_IDX_DEV_LIMIT, 33'h12c);
      rd(`DSO_IDX_SETTLE, 33'h12);
      rd(`DSO_IDX_GOAL, 33'h0);
      rd(16'h6000, 33'h100000000);
   endtask
   task automatic t_refuse();
      wr(`DSO_IDX_HALT, 32'h0, 1'b1);
      wr(`DSO_IDX_HALT, 32'h4, 1'b1);
      wr(`DSO_IDX_SHUTDOWN, 32'h2, 1'b1);
      wr(`DSO_IDX_MODE_SEL, 32'h2, 1'b1);
      wr(`DSO_IDX_DEV_LIMIT, 32'h0, 1'b1);
      wr(`DSO_IDX_DEV_LIMIT, 32'h7531, 1'b1);
      wr(`DSO_IDX_SETTLE, 32'hb5, 1'b1);
      wr(`DSO_IDX_CMD_POS, 32'h5, 1'b1);
      rd(`DSO_IDX_HALT, 33'h1);
      rd(`DSO_IDX_DEV_LIMIT, 33'h12c);
      wr(`DSO_IDX_DEV_LIMIT, 32'h7530, 1'b0);
      rd(`DSO_IDX_DEV_LIMIT, 33'h7530);
      wr(`DSO_IDX_DEV_LIMIT, 32'h12c, 1'b0);
   endtask
   task automatic t_stop();
      wr(`DSO_IDX_SHUTDOWN, 32'h0, 1'b0);
      @(posedge clk_sys) l_rdy <= 1'b1;
      @(posedge clk_sys) l_rdy <= 1'b0;
      #1 chk("power_off", 32'h1, 32'(pwr));
      chk("decel", 32'h0, 32'(decel));
      @(posedge clk_sys) op_en <= 1'b1;
      @(posedge clk_sys) op_en <= 1'b0;
      moving <= 1'b1;
      @(posedge clk_sys) l_sw <= 1'b1;
      @(posedge clk_sys) l_sw <= 1'b0;
      #1 chk("decel", 32'h1, 32'(decel));
      chk("power_off", 32'h0, 32'(pwr));
      cyc(3);
      chk("power_off", 32'h0, 32'(pwr));
      @(posedge clk_sys) moving <= 1'b0;
      for (k = 0; k < 8 && pwr !== 1'b1; k++) cyc(1);
      if (k == 8) begin
         $display("BAD power_off exp 1 got timeout");
         error_cnt++;
         summarize();
      end
      chk("decel", 32'h0, 32'(decel));
      @(posedge clk_sys) op_en <= 1'b1;
      @(posedge clk_sys) op_en <= 1'b0;
   endtask
   task automatic t_halt();
      for (int o = 1; o <= 3; o++) begin
         wr(`DSO_IDX_HALT, 32'(o), 1'b0);
         @(posedge clk_sys) cw <= 16'h0100;
         cyc(1);
         cyc(1);
         chk("halt decel", 32'(o), 32'(decel));
         chk("halt power", 32'h0, 32'(pwr));
         @(posedge clk_sys) cw <= 16'h0000;
         cyc(2);
         chk("halt end", 32'h0, 32'(decel));
      end
   endtask
   task automatic t_mode();
      logic [7:0] codes [5] = '{8'h03, 8'h06, 8'h08, 8'h09, 8'h00};
      @(posedge clk_sys) moving <= 1'b1;
      wr(`DSO_IDX_MODE_SEL, 32'h1, 1'b0);
      cyc(3);
      chk("mode frozen", 32'h0, 32'(mode_act));
      rd(`DSO_IDX_MODE_SHOWN, 33'h0);
      rd(`DSO_IDX_MODE_SEL, 33'h1);
      @(posedge clk_sys) moving <= 1'b0;
      cyc(3);
      chk("mode applied", 32'h1, 32'(mode_act));
      chk("tx mode", 32'h1, 32'(tx.mode_shown));
      foreach (codes[i]) begin
         wr(`DSO_IDX_MODE_SEL, 32'(codes[i]), 1'b0);
         cyc(2);
         chk("mode", 32'(codes[i]), 32'(mode_act));
      end
   endtask
   task automatic t_pdo();
      @(posedge clk_sys) begin
         moving <= 1'b1;
         send <= 1'b1;
         send_mode <= 8'h08;
         send_goal <= -32'sd7;
      end
      @(posedge clk_sys) send <= 1'b0;
      cyc(2);
      chk("goal", 32'hfffffff9, goal);
      @(posedge clk_sys) moving <= 1'b0;
      cyc(4);
      chk("rx mode", 32'h8, 32'(mode_act));
      rd(`DSO_IDX_GOAL, 33'hfffffff9);
      @(posedge clk_sys) begin
         wrap_on <= 1'b1;
         wrap_rng <= 32'd1000;
         cmd_p <= 32'sd1250;
         meas_p <= 32'sd2003;
         cmd_s <= 32'sd77;
         fb_s <= -32'sd9;
      end
      cyc(2);
      chk("tx cmd_pos", 32'd250, tx.cmd_pos);
      chk("tx meas_pos", 32'd3, tx.meas_pos);
      chk("tx cmd_speed", 32'd77, tx.cmd_speed);
      chk("tx fb_speed", 32'hfffffff7, tx.fb_speed);
      rd(`DSO_IDX_CMD_POS, 33'd250);
      @(posedge clk_sys) wrap_on <= 1'b0;
   endtask
   task automatic t_win();
      @(posedge clk_sys) begin
         cmd_p <= 32'sd0;
         meas_p <= 32'sd301;
      end
      cyc(2);
      chk("alarm", 32'h1, 32'(alarm));
      @(posedge clk_sys) meas_p <= 32'sd300;
      cyc(2);
      chk("alarm", 32'h0, 32'(alarm));
      @(posedge clk_sys) meas_p <= -32'sd5;
      cyc(2);
      chk("in_pos", 32'h0, 32'(in_pos));
      @(posedge clk_sys) offs <= 32'sd5;
      cyc(2);
      chk("in_pos", 32'h1, 32'(in_pos));
      @(posedge clk_sys) offs <= 32'sd0;
      wr(`DSO_IDX_SETTLE, 32'hb4, 1'b0);
      cyc(2);
      chk("in_pos", 32'h1, 32'(in_pos));
   endtask
   initial begin
      rst_n = 1'b0;
      req = '0;
      {l_rdy, l_sw, op_en, moving, wrap_on, send} = 6'h00;
      {cw, send_mode, send_goal, cmd_p, meas_p, cmd_s, fb_s, offs, wrap_rng} = '0;
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_reset();
      t_refuse();
      t_stop();
      t_halt();
      t_mode();
      t_pdo();
      t_win();
      summarize();
   end
endmodule // test_drive_stop_mode_objects
